// ---- hdl/rsa_pkg.sv ----
// package: offsets, reset values and field layouts of the strobe assignments
package rsa_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RSA_LS_LDO_OFFSET = 8'h25;
    localparam logic [7:0] RSA_GPO_OFFSET = 8'h26;
    localparam logic [7:0] RSA_LS_LDO_RESET = 8'h63;
    localparam logic [7:0] RSA_GPO_RESET = 8'h03;
    localparam logic [3:0] RSA_FIELD_DEFAULT_ON = 4'h3;
    localparam logic [3:0] RSA_FIELD_DEFAULT_OFF = 4'h0;
    localparam logic [3:0] RSA_STROBE_FIRST = 4'h3;
    localparam logic [3:0] RSA_STROBE_LAST = 4'hA;
    localparam int RSA_HI_LSB = 4;
    localparam int RSA_LO_LSB = 0;
    localparam int RSA_NUM_REGS = 2;
    localparam int RSA_NUM_OUTS = 3;
    localparam logic [1:0] RSA_NVM_IDLE_CYCLES = 2'h1;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsa_req_s;

    typedef struct packed {
        logic [3:0] linreg;
        logic [3:0] first_genout;
        logic [3:0] third_genout;
    } rsa_fields_s;
endpackage

// ---- hdl/rsa_nvm_shadow.sv ----
// small two-word shadow store standing for the non-volatile backing
`timescale 1ns/10ps
module rsa_nvm_shadow
    import rsa_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = RSA_NUM_REGS
)
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_wr,
    input wire logic i_idx,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [WIDTH-1:0] i_init0,
    input wire logic [WIDTH-1:0] i_init1,
    input wire logic i_rd_idx,
    output logic [WIDTH-1:0] o_rdata
);
    // the one-bit word index below serves exactly two words
    if (DEPTH != 2)
    begin : g_bad_depth
        $error("shadow store serves exactly two words");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];

    // --------------------------------------------------------------
    // storage; reset loads the factory image, read data registered
    // --------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            mem_q[0] <= i_init0;
            mem_q[1] <= i_init1;
            o_rdata <= '0;
        end
        else
        begin
            if (i_wr)
                mem_q[i_idx] <= i_wdata;
            o_rdata <= mem_q[i_rd_idx];
        end
    end
endmodule

// ---- hdl/rsa_strobe_regs.sv ----
// strobe-assignment registers for the linear regulator and general outputs
//
// What this block does
// - field values 3h..Ah enable the output at strobe three to ten.
// - values 0h-2h and Bh-Fh leave the output outside sequencer control.
// - register 0x26 resets to 0x3; bits 7-4 third output, 3-0 first.
// - linear regulator and first output default 3h; third output 0h.
// - strobes one and two run only while the freshness seal bit is zero.
`timescale 1ns/10ps
module rsa_strobe_regs
    import rsa_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_unlocked,
    input wire logic i_freshness_seal_bit,
    input wire logic [3:0] i_strobe_num,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_linreg_strobe_field_en,
    output logic o_first_genout_strobe_field_en,
    output logic o_third_genout_strobe_field_en,
    output logic o_linreg_sequenced,
    output logic o_first_genout_sequenced,
    output logic o_third_genout_sequenced,
    output logic o_early_strobe_allowed,
    output logic o_wr_refused
);
    // --------------------------------------------------------------
    // decoding helpers
    // --------------------------------------------------------------
    // window bounds live in the package, so a wider strobe range
    // needs no change in the decode itself
    // in range means the sequencer owns the output
    function automatic logic rsa_in_seq(input logic [3:0] f);
        rsa_in_seq = (f >= RSA_STROBE_FIRST) && (f <= RSA_STROBE_LAST);
    endfunction

    // fires when the current strobe matches an owned field
    function automatic logic rsa_hit(input logic [3:0] f,
                                     input logic [3:0] s);
        rsa_hit = rsa_in_seq(f) && (f == s);
    endfunction

    rsa_req_s req;
    rsa_fields_s fld;
    logic [7:0] ldo_q;
    logic [7:0] gpo_q;
    logic rd_pend_q;
    logic [1:0] nvm_wait_q;
    logic [7:0] nvm_rdata;

    // --------------------------------------------------------------
    // elaboration checks on the package layout
    // --------------------------------------------------------------
    // the two fields must be adjacent nibbles of one byte
    if (RSA_HI_LSB != RSA_LO_LSB + 4)
    begin : g_bad_layout
        $error("strobe fields must be adjacent nibbles");
    end
    // an empty window would leave every output unsequenced
    if (RSA_STROBE_FIRST > RSA_STROBE_LAST)
    begin : g_bad_window
        $error("strobe window must not be empty");
    end
    // the field decode below is written for exactly three outputs
    if (RSA_NUM_OUTS != 3)
    begin : g_bad_outs
        $error("three strobe fields are decoded");
    end
    // the shadow store indexes its two words by the one-bit hit_gpo decode
    if (RSA_NUM_REGS != 2)
    begin : g_bad_regs
        $error("two strobe registers are served");
    end

    // bus inputs travel as one snapshot so every decode agrees
    assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr,
                   wdata: i_reg_wdata};

    // --------------------------------------------------------------
    // address decode and write gating
    // --------------------------------------------------------------
    wire hit_ldo = (req.addr == RSA_LS_LDO_OFFSET);
    wire hit_gpo = (req.addr == RSA_GPO_OFFSET);
    wire hit_any = hit_ldo | hit_gpo;
    // locked writes are dropped, never partly applied; the refusal
    // is flagged one cycle later so software can notice that its
    // unlock step was missed
    wire wr_ok = req.wr & hit_any & i_unlocked;
    wire wr_bad = req.wr & hit_any & ~i_unlocked;

    // upper nibble of the regulator register is stored but drives
    // nothing here; only its low nibble belongs to the regulator
    assign fld.linreg = ldo_q[RSA_LO_LSB +: 4];
    assign fld.first_genout = gpo_q[RSA_LO_LSB +: 4];
    assign fld.third_genout = gpo_q[RSA_HI_LSB +: 4];

    // --------------------------------------------------------------
    // live register copies; reset values per register
    // --------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            ldo_q <= RSA_LS_LDO_RESET;
            gpo_q <= RSA_GPO_RESET;
        end
        else if (wr_ok)
        begin
            if (hit_ldo)
                ldo_q <= req.wdata;
            if (hit_gpo)
                gpo_q <= req.wdata;
        end
    end

    // live copy and store are written on the same edge, so a read
    // issued straight after a write already returns the new byte;
    // the store has no real persistence, it only mirrors the image
    // backing store follows every accepted write
    rsa_nvm_shadow #(
        .WIDTH(8),
        .DEPTH(RSA_NUM_REGS)
    ) u_nvm (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_wr(wr_ok),
        .i_idx(hit_gpo),
        .i_wdata(req.wdata),
        .i_init0(RSA_LS_LDO_RESET),
        .i_init1(RSA_GPO_RESET),
        .i_rd_idx(hit_gpo),
        .o_rdata(nvm_rdata)
    );

    // --------------------------------------------------------------
    // read path: data one cycle after the store's registered read
    // --------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            rd_pend_q <= 1'b0;
            nvm_wait_q <= 2'h0;
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            // both answers share one pipeline depth; the wait stage
            // stands in for the store's read on unmapped addresses
            rd_pend_q <= req.rd & hit_any;
            nvm_wait_q <= (req.rd & ~hit_any) ? RSA_NVM_IDLE_CYCLES : 2'h0;
            o_reg_rvalid <= rd_pend_q | (nvm_wait_q != 2'h0);
            // unmapped reads answer zero after the same two edges, so
            // a host waiting for rvalid never hangs on a bad address
            o_reg_rdata <= rd_pend_q ? nvm_rdata : 8'h00;
        end
    end

    // --------------------------------------------------------------
    // strobe decode toward the sequencer engine
    // --------------------------------------------------------------
    // strobes 1 and 2 are gated here since no field of ours uses them
    // the seal is a live level: once broken, strobes one and two are
    // refused from the next edge on, even in the middle of a sequence
    wire early_ok = ~i_freshness_seal_bit;
    wire early_strobe = (i_strobe_num == 4'h1) || (i_strobe_num == 4'h2);

    // every field is decoded the same way; one copy per output
    // index 0 linear regulator, 1 first output, 2 third output
    logic [3:0] fld_arr [RSA_NUM_OUTS];
    logic [RSA_NUM_OUTS-1:0] own_w;
    logic [RSA_NUM_OUTS-1:0] hit_w;

    assign fld_arr[0] = fld.linreg;
    assign fld_arr[1] = fld.first_genout;
    assign fld_arr[2] = fld.third_genout;

    for (genvar k = 0; k < RSA_NUM_OUTS; k++)
    begin : g_field
        // owned means some strobe from three to ten switches it on
        assign own_w[k] = rsa_in_seq(fld_arr[k]);
        // a hit needs both ownership and the matching strobe number
        assign hit_w[k] = rsa_hit(fld_arr[k], i_strobe_num);
    end

    // limitation: the fields only say when an output switches on;
    // the sequencer engine keeps all timing and switch-off order
    // outputs are registered so the engine sees clean levels; the
    // price is one cycle of lag after a field or strobe change

    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            o_linreg_strobe_field_en <= 1'b0;
            o_first_genout_strobe_field_en <= 1'b0;
            o_third_genout_strobe_field_en <= 1'b0;
            o_linreg_sequenced <= 1'b0;
            o_first_genout_sequenced <= 1'b0;
            o_third_genout_sequenced <= 1'b0;
            o_early_strobe_allowed <= 1'b0;
            o_wr_refused <= 1'b0;
        end
        else
        begin
            o_linreg_strobe_field_en <= hit_w[0];
            o_first_genout_strobe_field_en <= hit_w[1];
            o_third_genout_strobe_field_en <= hit_w[2];
            o_linreg_sequenced <= own_w[0];
            o_first_genout_sequenced <= own_w[1];
            o_third_genout_sequenced <= own_w[2];
            o_early_strobe_allowed <= early_ok & early_strobe;
            o_wr_refused <= wr_bad;
        end
    end
endmodule

// ---- sim/rsa_strobe_regs_asserts.sv ----
// checker: port-level properties of the strobe assignment registers
`timescale 1ns/10ps
module rsa_strobe_regs_asserts
    import rsa_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_unlocked,
    input wire logic i_freshness_seal_bit,
    input wire logic [3:0] i_strobe_num,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_linreg_strobe_field_en,
    input wire logic o_first_genout_sequenced,
    input wire logic o_third_genout_sequenced,
    input wire logic o_early_strobe_allowed,
    input wire logic o_wr_refused
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // locked writes are only flagged at the two mapped places
    wire logic mapped = i_reg_addr == RSA_LS_LDO_OFFSET
        || i_reg_addr == RSA_GPO_OFFSET;
    wire logic lk_wr = i_reg_wr && !i_unlocked && mapped;
    wire logic ok_wr = i_reg_wr && i_unlocked;
    sequence s_rd; i_reg_rd; endsequence
    sequence s_ans; ##2 o_reg_rvalid; endsequence
    property p_rvalid; s_rd |-> s_ans; endproperty
    property p_rdata0; !o_reg_rvalid |-> o_reg_rdata == 8'h00; endproperty
    property p_refuse; lk_wr |=> o_wr_refused; endproperty
    property p_norefuse; !lk_wr |=> !o_wr_refused; endproperty
    property p_early_on;
        i_strobe_num inside {4'h1, 4'h2} && !i_freshness_seal_bit
            |=> o_early_strobe_allowed;
    endproperty
    property p_early_off;
        i_freshness_seal_bit |=> !o_early_strobe_allowed;
    endproperty
    // first edge after reset is skipped: outputs reload from the fields;
    // a write moves them one edge after it is taken, so skip that too
    property p_hold;
        $past(i_reset_n) && !ok_wr && !$past(ok_wr)
            |=> $stable({o_first_genout_sequenced,
            o_third_genout_sequenced});
    endproperty
    property p_en;
        o_linreg_strobe_field_en |-> $past(i_strobe_num) inside {[3:10]};
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    a_rdata0: assert property (p_rdata0) else $error("stray data");
    a_refuse: assert property (p_refuse) else $error("no refusal");
    a_norefuse: assert property (p_norefuse) else $error("bad refuse");
    a_early_on: assert property (p_early_on) else $error("early off");
    a_early_off: assert property (p_early_off) else $error("early on");
    a_hold: assert property (p_hold) else $error("field moved");
    a_en: assert property (p_en) else $error("enable outside range");
endmodule

bind rsa_strobe_regs rsa_strobe_regs_asserts chk_u (.i_mclk, .i_reset_n,
    .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_unlocked, .i_freshness_seal_bit,
    .i_strobe_num, .o_reg_rdata, .o_reg_rvalid, .o_linreg_strobe_field_en,
    .o_first_genout_sequenced, .o_third_genout_sequenced,
    .o_early_strobe_allowed, .o_wr_refused);

// ---- sim/rsa_strobe_regs_bench.sv ----
// testbench: register access and decoding of the strobe assignments
`timescale 1ns/10ps
module rsa_strobe_regs_bench;
    import rsa_pkg::*;
    logic i_mclk = 0, i_reset_n = 0, i_reg_wr = 0, i_reg_rd = 0;
    logic i_unlocked = 0, i_freshness_seal_bit = 0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [3:0] i_strobe_num = 4'h0, v;
    logic o_reg_rvalid, o_wr_refused, o_early_strobe_allowed, ins;
    logic o_linreg_strobe_field_en, o_first_genout_strobe_field_en;
    logic o_third_genout_strobe_field_en, o_linreg_sequenced;
    logic o_first_genout_sequenced, o_third_genout_sequenced;
    int failures = 0, checks = 0, cyc = 0;
    rsa_strobe_regs dut_u (.i_mclk, .i_reset_n, .i_reg_wr, .i_reg_rd,
        .i_reg_addr, .i_reg_wdata, .i_unlocked, .i_freshness_seal_bit,
        .i_strobe_num, .o_reg_rdata, .o_reg_rvalid, .o_linreg_strobe_field_en,
        .o_first_genout_strobe_field_en, .o_third_genout_strobe_field_en,
        .o_linreg_sequenced, .o_first_genout_sequenced,
        .o_third_genout_sequenced, .o_early_strobe_allowed, .o_wr_refused);
    initial
        forever #5 i_mclk = ~i_mclk;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value at %0t: seen %h want %h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bus cycles: strobe held for the one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        // rvalid stands one cycle, one edge after the strobe drops
        @(posedge i_mclk);
        #1;
        chk({7'h00, o_reg_rvalid}, 8'h01);
        chk(o_reg_rdata, e);
    endtask
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        rd(RSA_LS_LDO_OFFSET, 8'h63);
        rd(RSA_GPO_OFFSET, 8'h03);
        chk({o_linreg_sequenced, o_first_genout_sequenced,
            o_third_genout_sequenced}, 8'h06);
        rd(8'h27, 8'h00);
        wr(RSA_GPO_OFFSET, 8'hFF);
        #1;
        chk({7'h00, o_wr_refused}, 8'h01);
        rd(RSA_GPO_OFFSET, 8'h03);
        @(posedge i_mclk);
        i_unlocked <= 1'b1;
        // every field code, with the strobe set to the same number
        for (int i = 0; i < 16; i++)
        begin
            v = i[3:0];
            ins = v >= 4'h3 && v <= 4'hA;
            wr(RSA_GPO_OFFSET, {v, v});
            wr(RSA_LS_LDO_OFFSET, {4'h6, v});
            #1;
            chk({7'h00, o_wr_refused}, 8'h00);
            @(posedge i_mclk);
            i_strobe_num <= v;
            rd(RSA_GPO_OFFSET, {v, v});
            rd(RSA_LS_LDO_OFFSET, {4'h6, v});
            chk({o_linreg_sequenced, o_first_genout_sequenced,
                o_third_genout_sequenced, o_linreg_strobe_field_en,
                o_first_genout_strobe_field_en,
                o_third_genout_strobe_field_en}, {6{ins}});
        end
        // early strobes gated by the seal bit; the seal is only driven
        // as a level here, never read back and acted on as status
        for (int s = 0; s < 8; s++)
        begin
            @(posedge i_mclk);
            i_strobe_num <= {2'h0, s[1:0]};
            i_freshness_seal_bit <= s[2];
            repeat (2) @(posedge i_mclk);
            #1;
            chk(o_early_strobe_allowed, (s[1] ^ s[0]) & ~s[2]);
        end
        // one strobe at a time: only the field that matches it fires
        wr(RSA_GPO_OFFSET, 8'h45);
        wr(RSA_LS_LDO_OFFSET, 8'h63);
        for (int s = 3; s < 6; s++)
        begin
            @(posedge i_mclk);
            i_strobe_num <= s[3:0];
            repeat (2) @(posedge i_mclk);
            #1;
            chk({o_linreg_strobe_field_en, o_first_genout_strobe_field_en,
                o_third_genout_strobe_field_en},
                {s == 3, s == 5, s == 4});
        end
        @(posedge i_mclk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        rd(RSA_GPO_OFFSET, 8'h03);
        finish_test();
    end
endmodule
